// ===== rtl/vstc_pkg.sv
// Constants, register map and timing counts for the valley switch timing control block
package vstc_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS     = 25;
  localparam int EVAL_PERIOD_MS    = 48;
  localparam int RS_LONG_NS        = 2500;
  localparam int RS_SHORT_NS       = 500;
  localparam int MAX_OFF_NS        = 50000;
  localparam int LEB_NS            = 220;
  localparam int MAX_ON_NS         = 25000;
  localparam int SW_BLANK_NS       = 190;
  localparam int OVP_BLANK_NS      = 1000;

  // Least times round up, longest times round down
  localparam int EVAL_CYCLES       = EVAL_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RS_LONG_CYCLES    = (RS_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RS_SHORT_CYCLES   = (RS_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_OFF_CYCLES    = MAX_OFF_NS / CLK_PERIOD_NS;
  localparam int LEB_CYCLES        = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_ON_CYCLES     = MAX_ON_NS / CLK_PERIOD_NS;
  localparam int SW_BLANK_CYCLES   = (SW_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVP_BLANK_CYCLES  = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Counter limits
  // ****************************************
  localparam logic [2:0] VALLEY_MIN = 3'h1;
  localparam logic [2:0] VALLEY_MAX = 3'h7;
  localparam logic [2:0] ZC_MIN     = 3'h0;
  localparam logic [2:0] ZC_MAX     = 3'h7;

  // ****************************************
  // Comparator input bit positions
  // ****************************************
  localparam int CMP_W       = 10;
  localparam int CMP_FB_LOW  = 0;
  localparam int CMP_FB_HIGH = 1;
  localparam int CMP_FB_RST  = 2;
  localparam int CMP_ZC      = 3;
  localparam int CMP_RS      = 4;
  localparam int CMP_OVP     = 5;
  localparam int CMP_CS_FB   = 6;
  localparam int CMP_CS_LIM  = 7;
  localparam int CMP_SW      = 8;
  localparam int CMP_LINE    = 9;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FOLD   = 8'h08;
  localparam logic [7:0] ADDR_LIMIT  = 8'h0C;

  localparam int CTRL_EN_BIT     = 0;
  localparam int ST_VALLEY_LSB   = 0;
  localparam int ST_ZC_LSB       = 4;
  localparam int ST_GATE_BIT     = 8;
  localparam int ST_LATCH_BIT    = 9;
  localparam int ST_OVP_BIT      = 10;
  localparam int ST_SW_BIT       = 11;
  localparam int ST_LINE_BIT     = 12;
  localparam int FOLD_THR_LSB    = 0;
  localparam int FOLD_BASE_LSB   = 8;
  localparam int FOLD_SHIFT_LSB  = 16;

  localparam logic       CTRL_EN_RST     = 1'b1;
  localparam logic [7:0] FOLD_THR_RST    = 8'h40;
  localparam logic [7:0] FOLD_BASE_RST   = 8'hFF;
  localparam logic [2:0] FOLD_SHIFT_RST  = 3'h1;

  localparam logic [1:0] HRESP_OKAY      = 2'h0;

endpackage

// ===== rtl/vstc_timer.sv
// Loadable down-counting timer used for every blanking and limit interval
`timescale 1ns/100ps
`default_nettype none
module vstc_timer #(
  parameter int W = 8
) (
  input  wire logic         hclk,     // System clock
  input  wire logic         hresetn,  // Async reset, active low
  input  wire logic         load,     // Restart with load_val
  input  wire logic [W-1:0] load_val, // Cycles to run
  output logic              busy      // High while counting
);

  typedef struct packed {
    logic [W-1:0] count;
  } vstc_timer_state_t;

  vstc_timer_state_t state_reg;
  vstc_timer_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (load) begin
      state_next.count = load_val;
    end else if (state_reg.count != '0) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = (state_reg.count != '0);

endmodule // vstc_timer
`default_nettype wire

// ===== rtl/vstc_core.sv
// Valley switch timing control: switch-on/off decisions, counters, protection and AHB registers
//
// How it works
// R01 - Feedback threshold results are evaluated once per 48 ms period.
// R02 - Feedback never above low zone threshold in period: valley count plus one.
// R03 - Above low zone but never above high zone: valley count unchanged.
// R04 - Above high zone but never above reset threshold: minus one, not below 1.
// R05 - Feedback above reset threshold forces valley count to 1 at once.
// R06 - Valley count stays within 1 to 7; out-of-range steps ignored.
// R07 - Valley count starts at 1 after reset.
// R08 - Zone thresholds selected from detected line voltage level.
// R09 - Zero-crossing counter ranges 0 to 7 and saturates.
// R10 - While off, each falling ring-sense crossing adds one to zero-crossing count.
// R11 - Zero-crossing counter clears whenever gate drive goes high.
// R12 - Ring overvoltage during off-time latches off after a blanking time.
// R13 - Ringing suppression after turn-off: long if ring level low, else short.
// R14 - Gate drive never rises while ringing suppression runs.
// R15 - After suppression, turn on when zero-crossing count reaches valley count.
// R16 - Gate off for maximum off-time turns on regardless of counters.
// R17 - Current signal above feedback level turns the switch off.
// R18 - Current compares ignored during leading-edge blanking; gives minimum on-time.
// R19 - Gate high longer than maximum on-time turns it off.
// R20 - Current above line-adjusted limit after blanking turns gate off immediately.
// R21 - Short-winding compare acts only when it lasts beyond its blanking time.
// R22 - Current limit reduced by offset from ring current above its threshold.
// R23 - Filtered short-winding compare while switch on latches the device off.
// R24 - All durations are clock counters; on-time, off-time, LEB and suppression ones restart at the relevant gate edge.
// R25 - Sticky flags record each threshold crossing during an evaluation period.
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module vstc_core #(
  parameter int EVAL_CYC    = vstc_pkg::EVAL_CYCLES,
  parameter int RS_LONG_CYC = vstc_pkg::RS_LONG_CYCLES,
  parameter int RS_SHRT_CYC = vstc_pkg::RS_SHORT_CYCLES,
  parameter int MAX_OFF_CYC = vstc_pkg::MAX_OFF_CYCLES,
  parameter int LEB_CYC     = vstc_pkg::LEB_CYCLES,
  parameter int MAX_ON_CYC  = vstc_pkg::MAX_ON_CYCLES,
  parameter int SW_CYC      = vstc_pkg::SW_BLANK_CYCLES,
  parameter int OVP_CYC     = vstc_pkg::OVP_BLANK_CYCLES,
  parameter int CUR_W       = 8
) (
  input  wire logic             hclk,                   // System clock, 40 MHz
  input  wire logic             hresetn,                // Async reset, active low
  input  wire logic             hsel,                   // AHB slave select
  input  wire logic [31:0]      haddr,                  // AHB address
  input  wire logic [1:0]       htrans,                 // AHB transfer type
  input  wire logic             hwrite,                 // AHB write
  input  wire logic [2:0]       hsize,                  // AHB size (word only)
  input  wire logic [31:0]      hwdata,                 // AHB write data
  input  wire logic             hready,                 // AHB bus ready
  output logic                  hreadyout,              // AHB slave ready
  output logic [1:0]            hresp,                  // AHB response
  output logic [31:0]           hrdata,                 // AHB read data
  input  wire logic             fb_above_low,           // Feedback above low zone threshold
  input  wire logic             fb_above_high,          // Feedback above high zone threshold
  input  wire logic             fb_above_reset,         // Feedback above count reset threshold
  input  wire logic             ring_above_zc,          // Ring sense above 100 mV level
  input  wire logic             ring_above_rs,          // Ring sense above ringing level
  input  wire logic             ring_above_ovp,         // Ring sense above overvoltage level
  input  wire logic             cs_above_fb,            // Current signal above feedback level
  input  wire logic             cs_above_limit,         // Current above line-adjusted limit
  input  wire logic             cs_above_short_winding, // Current above short winding level
  input  wire logic             line_high,              // High line voltage detected
  input  wire logic [CUR_W-1:0] ring_current,           // Measured ring pin current code
  output logic                  gate_drive_out,         // Gate drive, high = switch on
  output logic                  zone_high_select,       // Zone threshold set for high line
  output logic [CUR_W-1:0]      cs_limit_code,          // Folded-back current limit code
  output logic                  latched_off             // Latched-off protection state
);
  import vstc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [CMP_W-1:0] cmp_s1;
    logic [CMP_W-1:0] cmp_s2;
    logic [CUR_W-1:0] cur_s1;
    logic [CUR_W-1:0] cur_s2;
    logic             zc_prev;
    logic [2:0]       valley;
    logic [2:0]       zc_count;
    logic             seen_low;
    logic             seen_high;
    logic             seen_reset;
    logic             eval_run;
    logic             gate;
    logic             latched;
    logic             ovp_trip;
    logic             sw_trip;
    logic             enable;
    logic [CUR_W-1:0] fold_thr;
    logic [CUR_W-1:0] fold_base;
    logic [2:0]       fold_shift;
    logic [CUR_W-1:0] limit;
    logic             ap_valid;
    logic             ap_write;
    logic [7:0]       ap_addr;
    logic [31:0]      rdata;
  } vstc_core_state_t;

  localparam vstc_core_state_t ST_RST = '{
    valley:     VALLEY_MIN,
    zc_count:   ZC_MIN,
    enable:     CTRL_EN_RST,
    fold_thr:   CUR_W'(FOLD_THR_RST),
    fold_base:  CUR_W'(FOLD_BASE_RST),
    fold_shift: FOLD_SHIFT_RST,
    limit:      CUR_W'(FOLD_BASE_RST),
    default:    '0
  };

  vstc_core_state_t state_reg;
  vstc_core_state_t state_next;

  logic             turn_on;
  logic             turn_off;
  logic             eval_end;
  logic             ap_take;
  logic             off_trip;
  logic [CUR_W-1:0] excess;
  logic [CUR_W-1:0] offset;
  logic [31:0]      rd_mux;
  logic [7:0]       rs_val;

  logic eval_busy;
  logic rs_busy;
  logic off_busy;
  logic leb_busy;
  logic on_busy;
  logic sw_busy;
  logic ovp_busy;

  // ****************************************
  // Timers
  // ****************************************
  // Each restarts on a gate edge or on its own qualifying condition [R24]
  vstc_timer #(.W(21)) u_eval (
    .hclk(hclk), .hresetn(hresetn), .load(eval_end || !state_reg.eval_run),
    .load_val(21'(EVAL_CYC - 1)), .busy(eval_busy)
  );
  vstc_timer #(.W(8)) u_rs (
    .hclk(hclk), .hresetn(hresetn), .load(turn_off),
    .load_val(rs_val), .busy(rs_busy)
  );
  vstc_timer #(.W(12)) u_off (
    .hclk(hclk), .hresetn(hresetn), .load(turn_off),
    .load_val(12'(MAX_OFF_CYC)), .busy(off_busy)
  );
  vstc_timer #(.W(8)) u_leb (
    .hclk(hclk), .hresetn(hresetn), .load(turn_on),
    .load_val(8'(LEB_CYC)), .busy(leb_busy)
  );
  vstc_timer #(.W(12)) u_on (
    .hclk(hclk), .hresetn(hresetn), .load(turn_on),
    .load_val(12'(MAX_ON_CYC)), .busy(on_busy)
  );
  // Restarted whenever the compare drops, so only an unbroken run trips [R21]
  vstc_timer #(.W(8)) u_sw (
    .hclk(hclk), .hresetn(hresetn),
    .load(!(state_reg.gate && state_reg.cmp_s2[CMP_SW])),
    .load_val(8'(SW_CYC)), .busy(sw_busy)
  );
  vstc_timer #(.W(8)) u_ovp (
    .hclk(hclk), .hresetn(hresetn),
    .load(!(!state_reg.gate && state_reg.cmp_s2[CMP_OVP])),
    .load_val(8'(OVP_CYC)), .busy(ovp_busy)
  );

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.cmp_s1 = {line_high, cs_above_short_winding, cs_above_limit, cs_above_fb,
                         ring_above_ovp, ring_above_rs, ring_above_zc, fb_above_reset,
                         fb_above_high, fb_above_low};
    state_next.cmp_s2 = state_reg.cmp_s1;
    // Word sampled without handshake; a code may be off by one sample on a change
    state_next.cur_s1 = ring_current;
    state_next.cur_s2 = state_reg.cur_s1;
    state_next.zc_prev = state_reg.cmp_s2[CMP_ZC];

    // Longer suppression when ringing is still below its level [R13]
    rs_val = state_reg.cmp_s2[CMP_RS] ? 8'(RS_SHRT_CYC) : 8'(RS_LONG_CYC);

    // Protection latches, held until the next start-up reset
    off_trip = 1'b0;
    if (!state_reg.gate && state_reg.cmp_s2[CMP_OVP] && !ovp_busy) begin
      state_next.ovp_trip = 1'b1; // [R12]
      off_trip = 1'b1;
    end
    if (state_reg.gate && state_reg.cmp_s2[CMP_SW] && !sw_busy) begin
      state_next.sw_trip = 1'b1; // [R23]
      off_trip = 1'b1;
    end
    if (off_trip) begin
      state_next.latched = 1'b1;
    end

    // Switch-off decision
    turn_off = 1'b0;
    if (state_reg.gate) begin
      if (!leb_busy && state_reg.cmp_s2[CMP_CS_FB]) begin
        turn_off = 1'b1; // [R17] [R18]
      end
      if (!leb_busy && state_reg.cmp_s2[CMP_CS_LIM]) begin
        turn_off = 1'b1; // [R20]
      end
      if (!on_busy) begin
        turn_off = 1'b1; // [R19]
      end
      if (off_trip || state_reg.latched || !state_reg.enable) begin
        turn_off = 1'b1;
      end
    end

    // Switch-on decision; suppression blocks valley starts [R14]
    turn_on = 1'b0;
    if (!state_reg.gate && !state_reg.latched && !off_trip && state_reg.enable) begin
      if (!rs_busy && (state_reg.zc_count >= state_reg.valley)) begin
        turn_on = 1'b1; // [R15]
      end
      if (!off_busy) begin
        turn_on = 1'b1; // [R16]
      end
    end
    if (turn_on) begin
      state_next.gate = 1'b1;
    end else if (turn_off) begin
      state_next.gate = 1'b0;
    end

    // Zero-crossing counter
    if (turn_on) begin
      state_next.zc_count = ZC_MIN; // [R11]
    end else if (!state_reg.gate && state_reg.zc_prev && !state_reg.cmp_s2[CMP_ZC]
                 && state_reg.zc_count != ZC_MAX) begin
      state_next.zc_count = state_reg.zc_count + 1'b1; // [R09] [R10]
    end

    // Sticky threshold flags; a crossing in the closing cycle still counts [R25]
    state_next.eval_run = 1'b1;
    eval_end = state_reg.eval_run && !eval_busy; // [R01]
    state_next.seen_low   = !eval_end && (state_reg.seen_low || state_reg.cmp_s2[CMP_FB_LOW]);
    state_next.seen_high  = !eval_end && (state_reg.seen_high || state_reg.cmp_s2[CMP_FB_HIGH]);
    state_next.seen_reset = !eval_end && (state_reg.seen_reset || state_reg.cmp_s2[CMP_FB_RST]);
    if (state_reg.cmp_s2[CMP_FB_RST]) begin
      state_next.valley = VALLEY_MIN; // [R05]
    end else if (eval_end) begin
      if (state_reg.seen_reset) begin
        state_next.valley = VALLEY_MIN;
      end else if (state_reg.seen_high || state_reg.cmp_s2[CMP_FB_HIGH]) begin
        if (state_reg.valley != VALLEY_MIN) begin
          state_next.valley = state_reg.valley - 1'b1; // [R04] [R06]
        end
      end else if (state_reg.seen_low || state_reg.cmp_s2[CMP_FB_LOW]) begin
        state_next.valley = state_reg.valley; // [R03]
      end else if (state_reg.valley != VALLEY_MAX) begin
        state_next.valley = state_reg.valley + 1'b1; // [R02] [R06]
      end
    end

    // Foldback of the current limit [R22]
    excess = (state_reg.cur_s2 > state_reg.fold_thr) ?
             (state_reg.cur_s2 - state_reg.fold_thr) : '0;
    offset = excess >> state_reg.fold_shift;
    state_next.limit = (state_reg.fold_base > offset) ? (state_reg.fold_base - offset) : '0;

    // ****************************************
    // AHB-Lite slave, zero wait states
    // ****************************************
    rd_mux = '0;
    case (haddr[7:0])
      ADDR_CTRL: begin
        rd_mux[CTRL_EN_BIT] = state_reg.enable;
      end
      ADDR_STATUS: begin
        rd_mux[ST_VALLEY_LSB +: 3] = state_reg.valley;
        rd_mux[ST_ZC_LSB +: 3]     = state_reg.zc_count;
        rd_mux[ST_GATE_BIT]        = state_reg.gate;
        rd_mux[ST_LATCH_BIT]       = state_reg.latched;
        rd_mux[ST_OVP_BIT]         = state_reg.ovp_trip;
        rd_mux[ST_SW_BIT]          = state_reg.sw_trip;
        rd_mux[ST_LINE_BIT]        = state_reg.cmp_s2[CMP_LINE];
      end
      ADDR_FOLD: begin
        rd_mux[FOLD_THR_LSB +: CUR_W]  = state_reg.fold_thr;
        rd_mux[FOLD_BASE_LSB +: CUR_W] = state_reg.fold_base;
        rd_mux[FOLD_SHIFT_LSB +: 3]    = state_reg.fold_shift;
      end
      ADDR_LIMIT: begin
        rd_mux[CUR_W-1:0] = state_reg.limit;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
    ap_take = hsel && htrans[1] && hready;
    if (hready) begin
      state_next.ap_valid = ap_take;
      state_next.ap_write = hwrite;
      state_next.ap_addr  = haddr[7:0];
    end
    if (ap_take && !hwrite) begin
      state_next.rdata = rd_mux;
    end
    if (state_reg.ap_valid && state_reg.ap_write) begin
      case (state_reg.ap_addr)
        ADDR_CTRL: begin
          state_next.enable = hwdata[CTRL_EN_BIT];
        end
        ADDR_FOLD: begin
          state_next.fold_thr   = hwdata[FOLD_THR_LSB +: CUR_W];
          state_next.fold_base  = hwdata[FOLD_BASE_LSB +: CUR_W];
          state_next.fold_shift = hwdata[FOLD_SHIFT_LSB +: 3];
        end
        default: begin
          state_next.enable = state_reg.enable;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_RST; // [R07]
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign hreadyout        = 1'b1;
  assign hresp            = HRESP_OKAY;
  assign hrdata           = state_reg.rdata;
  assign gate_drive_out   = state_reg.gate;
  assign zone_high_select = state_reg.cmp_s2[CMP_LINE]; // [R08]
  assign cs_limit_code    = state_reg.limit;
  assign latched_off      = state_reg.latched;

endmodule // vstc_core
`default_nettype wire

// ===== dv/vstc_core_monitor.sv
// Port-level timing checks for the valley switch core
`timescale 1ns/100ps
`default_nettype none
module vstc_core_monitor
  import vstc_pkg::*;
#(
  parameter int LEB_CYC     = 3,
  parameter int MAX_ON_CYC  = 60,
  parameter int MAX_OFF_CYC = 100,
  parameter int RS_SHRT_CYC = 2
) (
  input wire logic       hclk,                   // Clock
  input wire logic       hresetn,                // Reset, active low
  input wire logic       hreadyout,              // Slave ready
  input wire logic [1:0] hresp,                  // Response
  input wire logic       gate_drive_out,         // Gate
  input wire logic       latched_off,            // Latch state
  input wire logic       cs_above_fb,            // Current trip
  input wire logic       cs_above_limit,         // Limit trip
  input wire logic       cs_above_short_winding, // Short winding
  input wire logic       ring_above_ovp,         // Overvoltage
  input wire logic       line_high,              // Line level
  input wire logic       zone_high_select        // Zone select
);
  // ****
  // Pulse length counters
  // ****
  logic [11:0] on_cnt;
  logic [11:0] off_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_cnt  <= '0;
      // Gate may rise at once after reset, so seed past suppression
      off_cnt <= 12'(RS_SHRT_CYC);
    end else begin
      on_cnt  <= gate_drive_out ? on_cnt + 12'h1 : 12'h0;
      off_cnt <= gate_drive_out ? 12'h0 : off_cnt + 12'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_fb_trip;
    (gate_drive_out && cs_above_fb)[*3];
  endsequence
  sequence s_lim_trip;
    (gate_drive_out && cs_above_limit)[*3];
  endsequence
  a_fb_turn_off: assert property (s_fb_trip |-> ##[0:4] !gate_drive_out)
    else $error("gate stayed on after current trip");
  a_limit_turn_off: assert property (s_lim_trip |-> ##[0:4] !gate_drive_out)
    else $error("gate stayed on after limit trip");
  a_min_on_time: assert property ($fell(gate_drive_out) && !latched_off |-> on_cnt >= LEB_CYC)
    else $error("on time below blanking");
  a_max_on_time: assert property (on_cnt <= MAX_ON_CYC + 2)
    else $error("on time above maximum");
  a_max_off_time: assert property (!latched_off |-> off_cnt <= MAX_OFF_CYC + 2)
    else $error("off time above maximum");
  a_ring_suppress: assert property ($rose(gate_drive_out) |-> off_cnt >= RS_SHRT_CYC)
    else $error("turn-on inside suppression");
  a_latch_hold: assert property (latched_off |=> latched_off && !gate_drive_out)
    else $error("latch released or gate on");
  a_ovp_latch: assert property ((!gate_drive_out && ring_above_ovp)[*6] |-> ##[0:3] latched_off)
    else $error("overvoltage did not latch");
  a_sw_latch: assert property ((gate_drive_out && cs_above_short_winding)[*4] |-> ##[0:4] latched_off)
    else $error("short winding did not latch");
  a_zone_line: assert property (line_high[*4] |-> zone_high_select)
    else $error("zone select not following line");
  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
    else $error("bus not ready or not okay");
endmodule // vstc_core_monitor
bind vstc_core vstc_core_monitor #(.LEB_CYC(LEB_CYC), .MAX_ON_CYC(MAX_ON_CYC),
  .MAX_OFF_CYC(MAX_OFF_CYC), .RS_SHRT_CYC(RS_SHRT_CYC)) i_vstc_core_monitor (.hclk, .hresetn,
  .hreadyout, .hresp, .gate_drive_out, .latched_off, .cs_above_fb, .cs_above_limit,
  .cs_above_short_winding, .ring_above_ovp, .line_high, .zone_high_select);
`default_nettype wire

// ===== dv/vstc_front_model.sv
// Behavioural front end: sense-pin ringing and switch current ramp
`timescale 1ns/100ps
`default_nettype none
module vstc_front_model (
  input  wire logic       hclk,           // Clock
  input  wire logic       gate_drive_out, // Gate from core
  input  wire logic       ring_en,        // Ringing after turn-off
  input  wire logic [7:0] cs_delay,       // On cycles before trip
  output logic            ring_above_zc,  // Ring above zero level
  output logic            cs_above_fb     // Current above feedback
);
  logic [7:0] on_n = 8'h0;
  logic [2:0] ph = 3'h0;
  initial begin
    ring_above_zc = 1'b0;
    cs_above_fb = 1'b0;
  end
  always @(posedge hclk) begin
    ph <= gate_drive_out ? 3'h0 : ph + 3'h1;
    // Pin clamped while on; one falling crossing per 8 cycles when off
    ring_above_zc <= !gate_drive_out && ring_en && ph[2];
    on_n <= gate_drive_out ? on_n + 8'h1 : 8'h0;
    cs_above_fb <= gate_drive_out && on_n >= cs_delay;
  end
endmodule // vstc_front_model
`default_nettype wire

// ===== dv/vstc_core_test.sv
// Register and switching tests for the valley switch core
`timescale 1ns/100ps
`default_nettype none
module vstc_core_test;
  import vstc_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0]  htrans = 2'h0, hresp;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, gate_drive_out, zone_high_select, latched_off;
  logic        fb_above_low = 0, fb_above_high = 0, fb_above_reset = 0, ring_above_zc;
  logic        ring_above_rs = 0, ring_above_ovp = 0, cs_above_fb, cs_above_limit = 0;
  logic        cs_above_short_winding = 0, line_high = 0, ring_en = 1;
  logic [7:0]  ring_current = '0, cs_limit_code, cs_delay = 8'h0A;
  wire         hready = hreadyout;
  int          err_total = 0, check_count = 0, cyc = 0, on_n, off_n;
  vstc_core #(.EVAL_CYC(200), .RS_LONG_CYC(20), .RS_SHRT_CYC(2), .MAX_OFF_CYC(100),
    .LEB_CYC(3), .MAX_ON_CYC(60), .SW_CYC(3), .OVP_CYC(4)) i_vstc_core (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .fb_above_low, .fb_above_high, .fb_above_reset, .ring_above_zc, .ring_above_rs,
    .ring_above_ovp, .cs_above_fb, .cs_above_limit, .cs_above_short_winding, .line_high,
    .ring_current, .gate_drive_out, .zone_high_select, .cs_limit_code, .latched_off);
  vstc_front_model i_vstc_front_model (.hclk, .gate_drive_out, .ring_en, .cs_delay,
    .ring_above_zc, .cs_above_fb);
  // ****
  // Clock, cycle count and watchdog
  // ****
  initial begin
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) cyc <= hresetn ? cyc + 1 : 0;
  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    close_out();
  end
  // ****
  // Tasks
  // ****
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rst;
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic vchk(input logic [2:0] e);
    bus(1'b0, ADDR_STATUS, '0);
    chk(q[2:0], e);
  endtask
  task automatic at(input int c);
    while (cyc < c) @(posedge hclk);
  endtask
  // Pulse v for six cycles, then hold rest
  task automatic fbp(input logic [2:0] v, input logic [2:0] rest);
    @(posedge hclk);
    {fb_above_reset, fb_above_high, fb_above_low} <= v;
    repeat (6) @(posedge hclk);
    {fb_above_reset, fb_above_high, fb_above_low} <= rest;
  endtask
  // Length of one whole on then off phase
  task automatic meas;
    on_n = 0;
    off_n = 0;
    while (gate_drive_out === 1'b1 && off_n < 500) begin
      @(posedge hclk);
      off_n++;
    end
    while (gate_drive_out !== 1'b1 && on_n < 500) begin
      @(posedge hclk);
      on_n++;
    end
    on_n = 0;
    off_n = 0;
    while (gate_drive_out === 1'b1 && on_n < 500) begin
      @(posedge hclk);
      on_n++;
    end
    while (gate_drive_out !== 1'b1 && off_n < 500) begin
      @(posedge hclk);
      off_n++;
    end
  endtask
  // ****
  // Tests
  // ****
  initial begin
    rst();
    bus(1'b0, ADDR_FOLD, '0);
    chk(q, 32'h0001FF40);
    ring_current <= 8'h60;
    bus(1'b1, ADDR_FOLD, 32'h0002FF40);
    repeat (6) @(posedge hclk);
    chk(cs_limit_code, 8'hF7);
    bus(1'b0, ADDR_LIMIT, '0);
    chk(q, 32'hF7);
    bus(1'b0, 8'h40, '0);
    chk(q, '0);
    bus(1'b1, ADDR_STATUS, 32'h7);
    line_high <= 1'b1;
    repeat (6) @(posedge hclk);
    chk(zone_high_select, 1'b1);
    at(100);
    vchk(3'h1);
    at(1450);
    fbp(3'h1, 3'h0);
    at(1500);
    vchk(3'h7);
    at(1650);
    fbp(3'h3, 3'h1);
    at(1700);
    vchk(3'h7);
    at(1900);
    vchk(3'h6);
    meas();
    chk(32'(off_n > 40), 1);
    at(2100);
    vchk(3'h6);
    at(2250);
    fbp(3'h7, 3'h0);
    vchk(3'h1);
    at(2450);
    fbp(3'h3, 3'h1);
    at(2700);
    vchk(3'h1);
    meas();
    chk(32'(off_n >= 20 && off_n < 25), 1);
    ring_above_rs <= 1'b1;
    meas();
    chk(32'(off_n < 16), 1);
    ring_en <= 1'b0;
    cs_delay <= 8'hC8;
    meas();
    chk(32'(on_n >= 58 && on_n <= 62), 1);
    chk(32'(off_n >= 99 && off_n <= 103), 1);
    cs_above_limit <= 1'b1;
    meas();
    chk(32'(on_n >= 3 && on_n < 8), 1);
    cs_above_limit <= 1'b0;
    cs_above_short_winding <= 1'b1;
    repeat (2) @(posedge hclk);
    cs_above_short_winding <= 1'b0;
    repeat (10) @(posedge hclk);
    chk(latched_off, 1'b0);
    ring_above_ovp <= 1'b1;
    repeat (150) @(posedge hclk);
    chk(latched_off, 1'b1);
    chk(gate_drive_out, 1'b0);
    ring_above_ovp <= 1'b0;
    line_high <= 1'b0;
    rst();
    cs_above_short_winding <= 1'b1;
    repeat (150) @(posedge hclk);
    chk(latched_off, 1'b1);
    close_out();
  end
endmodule // vstc_core_test
`default_nettype wire
